/* File: srap_pkg.sv */
// Shared constants for the four-wire serial register access port.
// Assumes a 100 MHz system clock on both ends.
package srap_pkg;

  localparam int FRAME_BITS = 40;
  localparam int DATA_BITS = 32;
  localparam int ADDR_BITS = 7;
  localparam int STAT_BITS = 8;
  localparam int CNT_BITS = 6;
  localparam logic [CNT_BITS-1:0] FRAME_CNT = 6'h28;

  // Frame layout
  localparam int WR_BIT_POS = 39;
  localparam int ADDR_MSB = 38;
  localparam int ADDR_LSB = 32;

  // Status byte layout
  localparam int ST_STOP_RIGHT = 7;
  localparam int ST_STOP_LEFT = 6;
  localparam int ST_POS_REACHED = 5;
  localparam int ST_VEL_REACHED = 4;
  localparam int ST_STANDSTILL = 3;
  localparam int ST_STALL = 2;
  localparam int ST_DRV_ERROR = 1;
  localparam int ST_RESET = 0;

  localparam logic [DATA_BITS-1:0] RET_RESET = 32'h0000_0000;
  localparam logic [STAT_BITS-1:0] STAT_RESET = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_MIN_PERIOD_NS = 100;
  localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                 / (2 * CLK_PERIOD_NS) + 3;
  localparam int CS_HIGH_NS = 100;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host command registers
  localparam logic [3:0] HREG_ADDR = 4'h0;
  localparam logic [3:0] HREG_WDATA = 4'h4;
  localparam logic [3:0] HREG_STATUS = 4'h8;
  localparam logic [3:0] HREG_RDATA = 4'hc;
  localparam int HST_BUSY = 0;
  localparam int HST_STAT_LSB = 8;

endpackage

/* File: srap_if.sv */
// Four-wire link between the host end and the device end.
// The shared output line is pulled high while no device drives it.
interface srap_if;
  logic sclk;
  logic chip_select_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic serial_out_line;

  assign serial_out_line = serial_out_oe_n ? 1'b1 : serial_out;

  modport host (output sclk, output chip_select_n, output serial_in,
                input serial_out_line);
  modport dev (input sclk, input chip_select_n, input serial_in,
               output serial_out, output serial_out_oe_n);
endinterface

/* File: srap_sync.sv */
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no word coherence is given.
module srap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

/* File: srap_dev.sv */
// Device end of the serial register access port.
// Assumes the register set sits behind the acc_* port and answers a read
// strobe with acc_rdata in the following cycle.
//
// Behaviour
// - Frames are 40 bits: address plus 32 data
// - Host keeps chip select low whole frame
// - Frame bit 39 set means write
// - Read data returns in the next frame
// - After a write, next frame echoes data
// - Read frame data bits are ignored
// - Status byte leads every returned frame
// - Status captured at access end, sent next
// - Bits 7..4: stops, position, velocity reached
// - Bit 3 standstill, bit 2 stall flag
// - Bit 1 driver error, bit 0 reset
// - Words right aligned, two's complement signed
// - Sample on rising, drive after falling, MSB first
// - Host gives at least 40 clocks
// - Extra bits pass through delayed 40 clocks
// - Chip select rise takes last 40 bits
// - Host bus clock at most 10 MHz
// - Clock mode 3, idle high
// - Asynchronous bus clock; minimum deselect time
// - All registers readable through this port
// - Strap selects serial port or UART
module srap_dev (
  input wire logic clock,
  input wire logic rst_b,
  srap_if.dev link,
  input wire logic uart_strap,
  input wire logic stop_right,
  input wire logic stop_left,
  input wire logic pos_reached,
  input wire logic vel_reached,
  input wire logic standstill,
  input wire logic stall_flag,
  input wire logic driver_error,
  input wire logic reset_flag,
  output logic acc_wr_ff,
  output logic acc_rd_ff,
  output logic [srap_pkg::ADDR_BITS-1:0] acc_addr_ff,
  output logic [srap_pkg::DATA_BITS-1:0] acc_wdata_ff,
  input wire logic [srap_pkg::DATA_BITS-1:0] acc_rdata,
  output logic port_active_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection

  logic [3:0] pins_raw;
  logic [3:0] pins_sync;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic strap_s;
  logic sclk_d_ff;
  logic cs_n_d_ff;

  // Bus clock is asynchronous to the system clock, so it is only sampled.
  // Idle-high pins pass inverted so the synchroniser's reset value equals
  // their idle level and no false edge follows reset.
  assign pins_raw = {uart_strap, link.serial_in, ~link.chip_select_n, ~link.sclk};

  srap_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign sclk_s = ~pins_sync[0];
  assign cs_n_s = ~pins_sync[1];
  assign sdi_s = pins_sync[2];
  assign strap_s = pins_sync[3];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_d_ff <= 1'b1;
      cs_n_d_ff <= 1'b1;
    end
    else
    begin
      sclk_d_ff <= sclk_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  logic selected;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  // Mode 3: rising edge samples, falling edge drives
  assign selected = ~cs_n_s & port_active_ff;
  assign sclk_rise = sclk_s & ~sclk_d_ff & selected;
  assign sclk_fall = ~sclk_s & sclk_d_ff & selected;
  assign cs_fall = ~cs_n_s & cs_n_d_ff & port_active_ff;
  assign cs_rise = cs_n_s & ~cs_n_d_ff & port_active_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture

  logic [1:0] strap_wait_ff;

  // The strap is caught once, on the third edge after reset: before that the
  // synchroniser still shows its reset value, not the pin
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_wait_ff <= 2'h0;
      port_active_ff <= 1'b0;
    end
    else if (strap_wait_ff != 2'h3)
    begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
      if (strap_wait_ff == 2'h2)
      begin
        port_active_ff <= ~strap_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and bit counter

  logic [srap_pkg::FRAME_BITS-1:0] shreg_ff;
  logic [srap_pkg::FRAME_BITS-1:0] nxt_shreg;
  logic [srap_pkg::CNT_BITS-1:0] bit_cnt_ff;
  logic [srap_pkg::CNT_BITS-1:0] nxt_bit_cnt;
  logic [srap_pkg::STAT_BITS-1:0] status_ff;
  logic [srap_pkg::DATA_BITS-1:0] ret_ff;
  logic cnt_full;

  assign cnt_full = (bit_cnt_ff == srap_pkg::FRAME_CNT);

  // Status leads, then returned data; the register keeps shifting after 40
  // bits so surplus input reappears 40 clocks later
  assign nxt_shreg = cs_fall ? {status_ff, ret_ff} :
                     sclk_rise ? {shreg_ff[srap_pkg::FRAME_BITS-2:0], sdi_s} :
                     shreg_ff;

  assign nxt_bit_cnt = cs_fall ? '0 :
                       (sclk_rise && !cnt_full) ? bit_cnt_ff + 1'b1 :
                       bit_cnt_ff;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shreg_ff <= '0;
      bit_cnt_ff <= '0;
    end
    else
    begin
      shreg_ff <= nxt_shreg;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output

  logic nxt_sdo;
  logic sdo_ff;
  logic sdo_oe_n_ff;

  // MSB first; first bit appears as soon as the frame opens
  assign nxt_sdo = cs_fall ? status_ff[srap_pkg::STAT_BITS-1] :
                   sclk_fall ? shreg_ff[srap_pkg::FRAME_BITS-1] :
                   sdo_ff;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdo_ff <= 1'b1;
      sdo_oe_n_ff <= 1'b1;
    end
    else
    begin
      sdo_ff <= nxt_sdo;
      sdo_oe_n_ff <= ~selected;
    end
  end

  assign link.serial_out = sdo_ff;
  assign link.serial_out_oe_n = sdo_oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at chip select release

  logic frame_ok;
  logic frame_wr;
  logic [srap_pkg::STAT_BITS-1:0] live_status;
  logic rd_wait_ff;

  // Short frames are dropped; only the last 40 bits count
  assign frame_ok = cs_rise & cnt_full;
  assign frame_wr = shreg_ff[srap_pkg::WR_BIT_POS];

  always_comb
  begin
    live_status = '0;
    live_status[srap_pkg::ST_STOP_RIGHT] = stop_right;
    live_status[srap_pkg::ST_STOP_LEFT] = stop_left;
    live_status[srap_pkg::ST_POS_REACHED] = pos_reached;
    live_status[srap_pkg::ST_VEL_REACHED] = vel_reached;
    live_status[srap_pkg::ST_STANDSTILL] = standstill;
    live_status[srap_pkg::ST_STALL] = stall_flag;
    live_status[srap_pkg::ST_DRV_ERROR] = driver_error;
    live_status[srap_pkg::ST_RESET] = reset_flag;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_wr_ff <= 1'b0;
      acc_rd_ff <= 1'b0;
      acc_addr_ff <= '0;
      acc_wdata_ff <= '0;
    end
    else
    begin
      // A read frame carries dummy data, so no write strobe for it
      acc_wr_ff <= frame_ok & frame_wr;
      acc_rd_ff <= frame_ok & ~frame_wr;
      if (frame_ok)
      begin
        acc_addr_ff <= shreg_ff[srap_pkg::ADDR_MSB:srap_pkg::ADDR_LSB];
        acc_wdata_ff <= shreg_ff[srap_pkg::DATA_BITS-1:0];
      end
    end
  end

  // Returned word: read data or echoed write data, loaded before the next
  // frame opens; the minimum deselect time covers the read latency
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_ff <= srap_pkg::STAT_RESET;
      ret_ff <= srap_pkg::RET_RESET;
      rd_wait_ff <= 1'b0;
    end
    else
    begin
      rd_wait_ff <= acc_rd_ff;
      if (cs_rise)
      begin
        status_ff <= live_status;
      end
      if (frame_ok && frame_wr)
      begin
        ret_ff <= shreg_ff[srap_pkg::DATA_BITS-1:0];
      end
      else if (rd_wait_ff)
      begin
        ret_ff <= acc_rdata;
      end
    end
  end

endmodule

/* File: srap_host.sv */
// Host end: a serial bus master driven through four command registers.
// Assumes software writes the data word before the address register,
// since the address write launches the frame.
module srap_host #(
  parameter int HALF_CYC = srap_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC = srap_pkg::CS_HIGH_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  srap_if.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff
);

  typedef enum logic [1:0] {
    SRAP_IDLE = 2'b00,
    SRAP_LEAD = 2'b01,
    SRAP_SHIFT = 2'b11,
    SRAP_GAP = 2'b10
  } srap_state_e;

  srap_state_e state_ff;
  logic [7:0] div_ff;
  logic [srap_pkg::CNT_BITS-1:0] bit_cnt_ff;
  logic [srap_pkg::FRAME_BITS-1:0] tx_ff;
  logic [srap_pkg::FRAME_BITS-1:0] rx_ff;
  logic [srap_pkg::DATA_BITS-1:0] wdata_ff;
  logic [srap_pkg::DATA_BITS-1:0] rdata_ff;
  logic [srap_pkg::STAT_BITS-1:0] stat_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic sdo_s;
  logic tick;
  logic start;
  logic busy;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  assign busy = (state_ff != SRAP_IDLE);
  assign start = reg_wr & (reg_addr == srap_pkg::HREG_ADDR) & ~busy;
  assign tick = (div_ff == 8'(HALF_CYC - 1));

  always_comb
  begin
    status_word = '0;
    status_word[srap_pkg::HST_BUSY] = busy;
    status_word[srap_pkg::HST_STAT_LSB +: srap_pkg::STAT_BITS] = stat_ff;
  end

  assign rd_mux = (reg_addr == srap_pkg::HREG_WDATA) ? wdata_ff :
                  (reg_addr == srap_pkg::HREG_STATUS) ? status_word :
                  (reg_addr == srap_pkg::HREG_RDATA) ? rdata_ff : 32'h0000_0000;

  srap_sync #(
    .WIDTH(1)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(link.serial_out_line),
    .sync_out(sdo_s)
  );

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata_ff <= '0;
      wdata_ff <= '0;
    end
    else
    begin
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
      if (reg_wr && reg_addr == srap_pkg::HREG_WDATA && !busy)
      begin
        wdata_ff <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine: clock idles high, drive after falling, sample on rising

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= SRAP_IDLE;
      div_ff <= '0;
      bit_cnt_ff <= '0;
      tx_ff <= '0;
      rx_ff <= '0;
      rdata_ff <= '0;
      stat_ff <= '0;
      sclk_ff <= 1'b1;
      cs_n_ff <= 1'b1;
    end
    else
    begin
      // The gap counts past a half period, so tick must not restart it there
      div_ff <= ((tick && state_ff != SRAP_GAP) || state_ff == SRAP_IDLE) ? 8'h00 :
                div_ff + 8'h01;
      case (state_ff)
        SRAP_IDLE:
        begin
          if (start)
          begin
            // Bit 7 of the written byte becomes frame bit 39, the write flag
            tx_ff <= {reg_wdata[7:0], wdata_ff};
            cs_n_ff <= 1'b0;
            bit_cnt_ff <= '0;
            state_ff <= SRAP_LEAD;
          end
        end
        SRAP_LEAD:
        begin
          if (tick)
          begin
            state_ff <= SRAP_SHIFT;
          end
        end
        SRAP_SHIFT:
        begin
          if (tick && sclk_ff)
          begin
            if (bit_cnt_ff == srap_pkg::FRAME_CNT)
            begin
              // Chip select held low across all 40 clocks
              cs_n_ff <= 1'b1;
              stat_ff <= rx_ff[srap_pkg::FRAME_BITS-1:srap_pkg::DATA_BITS];
              rdata_ff <= rx_ff[srap_pkg::DATA_BITS-1:0];
              state_ff <= SRAP_GAP;
            end
            else
            begin
              sclk_ff <= 1'b0;
              if (bit_cnt_ff != '0)
              begin
                tx_ff <= {tx_ff[srap_pkg::FRAME_BITS-2:0], 1'b0};
              end
            end
          end
          else if (tick)
          begin
            sclk_ff <= 1'b1;
            rx_ff <= {rx_ff[srap_pkg::FRAME_BITS-2:0], sdo_s};
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
          end
        end
        SRAP_GAP:
        begin
          // Deselect time lets the device fetch the next returned word
          if (div_ff == 8'(GAP_CYC - 1))
          begin
            state_ff <= SRAP_IDLE;
          end
        end
        default:
        begin
          state_ff <= SRAP_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.chip_select_n = cs_n_ff;
  assign link.serial_in = tx_ff[srap_pkg::FRAME_BITS-1];

endmodule

/* File: srap_link_monitor.sv */
// Concurrent checks on the four-wire link between host end and device end.
// Assumes both ends share one system clock; the host makes the link clock.
module srap_link_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic serial_out_line
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [5:0] GAP_MIN = 6'(srap_pkg::CS_HIGH_CYC);
  logic sclk_q_ff;
  logic [5:0] rise_cnt_ff;
  logic [5:0] nxt_rise_cnt;
  logic [5:0] high_cnt_ff;
  logic [5:0] nxt_high_cnt;
  wire sclk_rise = sclk & ~sclk_q_ff;

  assign nxt_rise_cnt = chip_select_n ? 6'h00 : rise_cnt_ff + {5'h00, sclk_rise};
  // Saturates so that a long idle span never wraps into a false short gap
  assign nxt_high_cnt = !chip_select_n ? 6'h00 :
                        (high_cnt_ff == 6'h3f) ? 6'h3f : high_cnt_ff + 6'h01;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q_ff <= 1'b1;
      rise_cnt_ff <= 6'h00;
      high_cnt_ff <= 6'h3f;
    end
    else
    begin
      sclk_q_ff <= sclk;
      rise_cnt_ff <= nxt_rise_cnt;
      high_cnt_ff <= nxt_high_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_frame_length: assert property ($rose(chip_select_n) |-> rise_cnt_ff == 6'h28)
    else $error("Frame without exactly 40 link clocks");
  a_cs_gap: assert property ($fell(chip_select_n) |-> high_cnt_ff >= GAP_MIN)
    else $error("Chip select high too briefly");
  a_cs_held: assert property ($fell(sclk) |-> !chip_select_n [*8])
    else $error("Chip select released in mid frame");
  a_idle_high: assert property (chip_select_n |-> sclk)
    else $error("Link clock low outside a frame");
  a_sclk_rate: assert property (($rose(sclk) || $fell(sclk)) |=> $stable(sclk) [*4])
    else $error("Link clock faster than allowed");
  a_mosi_hold: assert property ((sclk && $past(sclk) && !chip_select_n
    && !$past(chip_select_n)) |-> $stable(serial_in))
    else $error("Host data moved while link clock high");
  a_miso_hold: assert property ((sclk && !chip_select_n) [*6] |-> $stable(serial_out))
    else $error("Device data moved while link clock high");
  a_out_release: assert property (chip_select_n [*5] |-> serial_out_oe_n && serial_out_line)
    else $error("Device drives output while deselected");
  a_out_enable: assert property ((!chip_select_n) [*5] |-> !serial_out_oe_n)
    else $error("Device silent during a frame");
endmodule

/* File: serial_register_access_port_bench.sv */
// Testbench: host end and device end joined over one link, with a register
// set model behind the device's access port. Assumes the strap selects serial.
module serial_register_access_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff;
  logic [7:0] flags = 8'h00;
  logic acc_wr_ff;
  logic acc_rd_ff;
  logic [6:0] acc_addr_ff;
  logic [31:0] acc_wdata_ff;
  logic [31:0] acc_rdata;
  logic port_active_ff;
  logic [31:0] mem [128];
  logic [39:0] mosi_sh = 40'h00_0000_0000;
  logic [39:0] miso_sh = 40'h00_0000_0000;
  int n_errors = 0;
  int samples_checked = 0;

  srap_if link();
  srap_host i_srap_host (.clock(clock), .rst_b(rst_b), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));
  srap_dev i_srap_dev (.clock(clock), .rst_b(rst_b), .link(link), .uart_strap(1'b0),
    .stop_right(flags[7]), .stop_left(flags[6]), .pos_reached(flags[5]),
    .vel_reached(flags[4]), .standstill(flags[3]), .stall_flag(flags[2]),
    .driver_error(flags[1]), .reset_flag(flags[0]), .acc_wr_ff(acc_wr_ff),
    .acc_rd_ff(acc_rd_ff), .acc_addr_ff(acc_addr_ff), .acc_wdata_ff(acc_wdata_ff),
    .acc_rdata(acc_rdata), .port_active_ff(port_active_ff));
  srap_link_monitor i_srap_link_monitor (.clock(clock), .rst_b(rst_b), .sclk(link.sclk),
    .chip_select_n(link.chip_select_n), .serial_in(link.serial_in),
    .serial_out(link.serial_out), .serial_out_oe_n(link.serial_out_oe_n),
    .serial_out_line(link.serial_out_line));

  always #5 clock = ~clock;

  // Address stands until the next frame, so a plain lookup meets the read timing
  assign acc_rdata = mem[acc_addr_ff];
  always @(posedge clock)
    if (acc_wr_ff)
      mem[acc_addr_ff] <= acc_wdata_ff;

  // Both wires as seen at each link clock rise, first bit ends up on top
  always @(posedge link.sclk)
  begin
    if (!link.chip_select_n)
    begin
      mosi_sh <= {mosi_sh[38:0], link.serial_in};
      miso_sh <= {miso_sh[38:0], link.serial_out_line};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] init_word(input logic [6:0] a);
    return {25'h100_0000, a};
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] expected);
    samples_checked++;
    if (seen !== expected)
    begin
      n_errors++;
      $display("Error at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, expected);
    end
  endtask

  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask

  // One whole 40-bit frame; judges wires and host registers against expectations
  task automatic run_frame(input logic [7:0] cmd, input logic [31:0] wd,
                           input logic [7:0] st, input logic [31:0] ret);
    logic [31:0] d;
    int polls;
    d = 32'h0000_0001;
    polls = 0;
    reg_write(srap_pkg::HREG_WDATA, wd);
    reg_write(srap_pkg::HREG_ADDR, {24'h00_0000, cmd});
    while (d[0] !== 1'b0 && polls < 1000)
    begin
      reg_read(srap_pkg::HREG_STATUS, d);
      polls++;
    end
    check(40'(d[0]), 40'h00_0000_0000);
    check(40'(d[15:8]), 40'(st));
    check(mosi_sh, {cmd, wd});
    check(miso_sh, {st, ret});
    reg_read(srap_pkg::HREG_RDATA, d);
    check(40'(d), 40'(ret));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    check(40'(port_active_ff), 40'(1'b1));
    check(40'(link.serial_out_oe_n), 40'(1'b1));
    check(40'(link.sclk), 40'(1'b1));
  endtask

  task automatic t_first_frame();
    @(posedge clock);
    flags <= 8'ha5;
    run_frame(8'h05, 32'hffff_ffff, 8'h00, 32'h0000_0000);
  endtask

  // Flags move right after the frame; the next status must still be the old set
  task automatic t_write_after_read();
    @(posedge clock);
    flags <= 8'h5a;
    run_frame(8'h85, 32'h8000_1234, 8'ha5, init_word(7'h05));
    check(40'(mem[5]), 40'(32'h8000_1234));
  endtask

  task automatic t_pipeline();
    run_frame(8'h07, 32'hdead_beef, 8'h5a, 32'h8000_1234);
    run_frame(8'h80, 32'h0000_00ff, 8'h5a, init_word(7'h07));
    run_frame(8'h81, 32'h7fff_ffff, 8'h5a, 32'h0000_00ff);
    run_frame(8'h01, 32'h0000_0000, 8'h5a, 32'h7fff_ffff);
    check(40'(mem[0]), 40'(32'h0000_00ff));
    check(40'(mem[7]), 40'(init_word(7'h07)));
  endtask

  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = init_word(7'(i));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    t_reset_state();
    t_first_frame();
    t_write_after_read();
    t_pipeline();
    conclude();
  end

  // Six frames take about 40 us, well under the 200 us limit; this only cuts a hang short
  initial
  begin
    #200_000;
    n_errors++;
    conclude();
  end
endmodule
